// file: khp_pkg.sv
// Shared constants and types for the three-port host byte interface
package khp_pkg;

    // Host I/O base of each port; the data register sits at the base, command/status at base + 1
    localparam logic [15:0] SW_PORT_BASE = 16'h0ca2;
    localparam logic [15:0] MGMT_PORT_BASE = 16'h0ca4;
    localparam logic [15:0] EC_PORT_BASE = 16'h0ca6;
    localparam logic ADDR_SEL_DATA = 1'h0;

    localparam int NUM_PORTS = 3;
    localparam logic [1:0] PORT_SW = 2'h0;
    localparam logic [1:0] PORT_MGMT = 2'h1;
    localparam logic [1:0] PORT_EC = 2'h2;

    // Protocol state after reset is the error state
    localparam logic [1:0] PROTO_RESET = 2'h3;

    // Controller health codes
    localparam logic [1:0] HEALTH_READY = 2'h0;
    localparam logic [1:0] HEALTH_HW_ERR = 2'h1;
    localparam logic [1:0] HEALTH_FW_CSUM = 2'h2;
    localparam logic [1:0] HEALTH_NOT_READY = 2'h3;

    // Reset values of the byte registers
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // Host command codes watched on the software port
    localparam logic [7:0] CMD_GET_STATUS_ABORT = 8'h60;
    localparam logic [7:0] CMD_WRITE_START = 8'h61;
    localparam logic [7:0] CMD_WRITE_END = 8'h62;
    localparam logic [1:0] LUN_ACCEPTED = 2'h0;

    // Receive message queue
    localparam int RXQ_DEPTH = 2;
    localparam logic [1:0] RXQ_FULL_COUNT = 2'h2;
    localparam logic [1:0] RXQ_EMPTY_COUNT = 2'h0;

    // Software port write-phase tracker, Gray coded along the write path
    typedef enum logic [1:0] {
        TRK_IDLE = 2'h0,
        TRK_EXPECT_NETFN = 2'h1,
        TRK_BODY = 2'h3,
        TRK_LAST = 2'h2
    } khp_track_e;

endpackage

// file: khp_port_regs.sv
// Register set of one host byte port: data in, data out, command flag, flags and status
`timescale 1ns/1ps
module khp_port_regs
    import khp_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic hostWr,
    input wire logic hostCmd,
    input wire logic [7:0] hostWdata,
    input wire logic hostRdData,
    input wire logic ctlRd,
    input wire logic ctlWr,
    input wire logic [7:0] ctlWdata,
    input wire logic stateWr,
    input wire logic [1:0] stateVal,
    input wire logic [1:0] health,
    input wire logic attn,
    output logic [7:0] dataIn,
    output logic [7:0] dataOut,
    output logic cmdFlag,
    output logic inputFullFlag,
    output logic outputFullFlag,
    output logic [7:0] status
);

    logic [1:0] protoState;
    wire next_inputFullFlag = hostWr | (inputFullFlag & ~ctlRd);
    wire next_outputFullFlag = ctlWr | (outputFullFlag & ~hostRdData);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dataIn <= BYTE_RESET;
            dataOut <= BYTE_RESET;
            cmdFlag <= 1'h0;
            inputFullFlag <= 1'h0;
            outputFullFlag <= 1'h0;
            protoState <= PROTO_RESET;
        end else begin
            inputFullFlag <= next_inputFullFlag;
            outputFullFlag <= next_outputFullFlag;
            if (hostWr) begin
                dataIn <= hostWdata;
                cmdFlag <= hostCmd;
            end
            if (ctlWr) begin
                dataOut <= ctlWdata;
            end
            if (stateWr) begin
                protoState <= stateVal;
            end
        end
    end

    // Status is built from internal state and the health and attention inputs, so no host access can write it
    assign status = {protoState, health, cmdFlag, attn, inputFullFlag, outputFullFlag};

    property p_input_full_set;
        @(posedge mclk) disable iff (rst) hostWr |=> inputFullFlag;
    endproperty
    a_input_full_set: assert property (p_input_full_set) else $error("input full not set by host write");

    property p_input_full_clr;
        @(posedge mclk) disable iff (rst) (ctlRd && !hostWr) |=> !inputFullFlag;
    endproperty
    a_input_full_clr: assert property (p_input_full_clr) else $error("input full not cleared by controller read");

    property p_output_full_cycle;
        @(posedge mclk) disable iff (rst) (hostRdData && !ctlWr) |=> !outputFullFlag;
    endproperty
    a_output_full_cycle: assert property (p_output_full_cycle) else $error("output full not cleared by host read");

    property p_cmd_flag;
        @(posedge mclk) disable iff (rst) hostWr |=> (cmdFlag == $past(hostCmd)) && (dataIn == $past(hostWdata));
    endproperty
    a_cmd_flag: assert property (p_cmd_flag) else $error("command flag or data in wrong after host write");

endmodule // khp_port_regs

// file: khp_host_port_set.sv
// Three host byte ports with address decode, link crossing, priority, attention and receive queue
//
// Function
// - Three independent byte ports for three clients
// - Decode each port's two-address I/O pair
// - Management mode port is serviced first
// - Two-entry receive queue via software port only
// - Status register bits are read-only to host
// - Bits 7:6 report port protocol state
// - Bits 5:4 report controller health code; EC port always reads ready
// - Bit 3 records command or data write
// - Bit 2 flags a pending controller message, except on EC port (held at 0)
// - Input full: host write sets, controller clears
// - Output full: controller write sets, host clears
// - Reset: protocol error state, health ready
// - Health reads not ready while controller busy, on software and management ports only
// - Software port accepts only logical unit zero; other units are still taken in and raise swLunErr
// - Software port attention rising raises enabled host interrupt
// - Attention set by queue, event, pre-timeout
// - Attention clears once all causes flushed
`timescale 1ns/1ps
module khp_host_port_set
    import khp_pkg::*;
#(
    parameter logic [15:0] SW_BASE = SW_PORT_BASE
)(
    input wire logic mclk,
    input wire logic rst,
    input wire logic lclk,
    input wire logic [15:0] ioAddr,
    input wire logic ioWrite,
    input wire logic ioRead,
    input wire logic [7:0] ioWdata,
    output logic [7:0] ioRdata,
    output logic ioDone,
    output logic ioBusy,
    input wire logic ctlRead,
    output logic ctlRvalid,
    output logic [7:0] ctlRdata,
    output logic ctlRcmd,
    output logic [1:0] ctlRport,
    output logic ctlPendValid,
    output logic [1:0] ctlPendPort,
    output logic [2:0] ctlOutputFullFlag,
    input wire logic ctlWrite,
    input wire logic [1:0] ctlWport,
    input wire logic [7:0] ctlWdata,
    input wire logic ctlStateWr,
    input wire logic [1:0] ctlStatePort,
    input wire logic [1:0] ctlStateVal,
    input wire logic [1:0] ctlHealth,
    input wire logic ctlBusy,
    input wire logic mgmtMsgPending,
    input wire logic swMsgPending,
    input wire logic eventPending,
    input wire logic preTimeout,
    input wire logic globalIrqEnable,
    output logic hostAttnIrq,
    input wire logic rxqPush,
    input wire logic [7:0] rxqData,
    input wire logic rxqToHost,
    output logic [1:0] rxqCount,
    input wire logic ctlFlagClr,
    output logic swAbortFlag,
    output logic swLunErr
);

    // ---------------- Link side, on the host bus clock ----------------
    logic lrstMeta;
    logic lrst;
    logic reqTgl;
    logic [1:0] reqPort;
    logic reqA0;
    logic reqIsWrite;
    logic [7:0] reqData;
    logic ackMeta;
    logic ackSync;
    logic ackSeen;
    logic ackTgl;
    logic [7:0] ackData;

    // Reset asserts at once and releases in step with the link clock
    always_ff @(posedge lclk or posedge rst) begin
        if (rst) begin
            lrstMeta <= 1'h1;
            lrst <= 1'h1;
        end else begin
            lrstMeta <= 1'h0;
            lrst <= lrstMeta;
        end
    end

    // Any master other than the host is assumed never to hit these pairs
    wire hitSw = ioAddr[15:1] == SW_BASE[15:1];
    wire hitMgmt = ioAddr[15:1] == MGMT_PORT_BASE[15:1];
    wire hitEc = ioAddr[15:1] == EC_PORT_BASE[15:1];
    wire ioHit = hitSw | hitMgmt | hitEc;
    wire [1:0] hitPort = hitMgmt ? PORT_MGMT : (hitEc ? PORT_EC : PORT_SW);
    wire ioAccept = (ioWrite | ioRead) & ioHit & ~ioBusy;
    wire ackNew = ackSync ^ ackSeen;

    always_ff @(posedge lclk or posedge rst) begin
        if (rst) begin
            ackMeta <= 1'h0;
            ackSync <= 1'h0;
        end else begin
            ackMeta <= ackTgl;
            ackSync <= ackMeta;
        end
    end

    // Request fields stay frozen while busy, which makes them safe to read on the other clock
    always_ff @(posedge lclk or posedge lrst) begin
        if (lrst) begin
            reqTgl <= 1'h0;
            reqPort <= PORT_SW;
            reqA0 <= ADDR_SEL_DATA;
            reqIsWrite <= 1'h0;
            reqData <= BYTE_RESET;
            ioBusy <= 1'h0;
            ackSeen <= 1'h0;
            ioDone <= 1'h0;
            ioRdata <= BYTE_RESET;
        end else begin
            ioDone <= ackNew;
            if (ioAccept) begin
                reqTgl <= ~reqTgl;
                reqPort <= hitPort;
                reqA0 <= ioAddr[0];
                reqIsWrite <= ioWrite;
                reqData <= ioWdata;
                ioBusy <= 1'h1;
            end else if (ackNew) begin
                ackSeen <= ackSync;
                ioBusy <= 1'h0;
                ioRdata <= ackData;
            end
        end
    end

    sequence s_host_req;
        ioAccept;
    endsequence
    property p_host_done;
        @(posedge lclk) disable iff (lrst) s_host_req |-> ##[2:16] ioDone;
    endproperty
    a_host_done: assert property (p_host_done) else $error("host access not completed in time");

    // ---------------- Controller side, on mclk ----------------
    logic reqMeta;
    logic reqSync;
    logic reqSeen;
    logic [1:0] healthReg;
    logic swAttn;
    logic mgmtAttn;
    logic [7:0] rxqMem [RXQ_DEPTH];
    logic rxqWptr;
    logic rxqRptr;
    khp_track_e trk;
    khp_track_e next_trk;

    logic [NUM_PORTS-1:0][7:0] portDataIn;
    logic [NUM_PORTS-1:0][7:0] portDataOut;
    logic [NUM_PORTS-1:0][7:0] portStatus;
    logic [NUM_PORTS-1:0] portCmd;
    logic [NUM_PORTS-1:0] portInputFullFlag;
    logic [NUM_PORTS-1:0] portOutputFullFlag;
    logic [NUM_PORTS-1:0] hostWrSel;
    logic [NUM_PORTS-1:0] hostRdSel;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reqMeta <= 1'h0;
            reqSync <= 1'h0;
        end else begin
            reqMeta <= reqTgl;
            reqSync <= reqMeta;
        end
    end

    wire hostGo = reqSync ^ reqSeen;
    wire anyInputFull = |portInputFullFlag;
    // Management mode port wins so that handler latency stays short
    wire [1:0] grant = portInputFullFlag[PORT_MGMT] ? PORT_MGMT : (portInputFullFlag[PORT_SW] ? PORT_SW : PORT_EC);
    wire ctlReadGo = ctlRead & anyInputFull;
    wire swCtlWrite = ctlWrite & (ctlWport == PORT_SW);
    wire rxqMove = rxqToHost & (rxqCount != RXQ_EMPTY_COUNT) & ~swCtlWrite;
    wire rxqDoPush = rxqPush & (rxqCount != RXQ_FULL_COUNT);
    wire [1:0] next_rxqCount = rxqCount + {1'h0, rxqDoPush} - {1'h0, rxqMove};
    wire [7:0] rxqHead = rxqMem[rxqRptr];
    wire swAttnCond = (rxqCount != RXQ_EMPTY_COUNT) | eventPending | preTimeout | swMsgPending;
    wire [NUM_PORTS-1:0] portAttn = {1'h0, mgmtAttn, swAttn};

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reqSeen <= 1'h0;
            ackTgl <= 1'h0;
            ackData <= BYTE_RESET;
        end else if (hostGo) begin
            reqSeen <= reqSync;
            ackTgl <= ~ackTgl;
            ackData <= (reqA0 == ADDR_SEL_DATA) ? portDataOut[reqPort] : portStatus[reqPort];
        end
    end

    for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
        localparam logic [1:0] IDX = 2'(i);
        wire queueFeed = (IDX == PORT_SW) & rxqMove;
        wire ctlWrSel = (ctlWrite & (ctlWport == IDX)) | queueFeed;
        wire [7:0] ctlWrData = queueFeed ? rxqHead : ctlWdata;
        wire ctlRdSel = ctlReadGo & (grant == IDX);
        wire stateSel = ctlStateWr & (ctlStatePort == IDX);
        wire [1:0] portHealth = (IDX == PORT_EC) ? HEALTH_READY : healthReg;
        assign hostWrSel[i] = hostGo & reqIsWrite & (reqPort == IDX);
        assign hostRdSel[i] = hostGo & ~reqIsWrite & (reqA0 == ADDR_SEL_DATA) & (reqPort == IDX);

        khp_port_regs u_regs (
            .mclk(mclk),
            .rst(rst),
            .hostWr(hostWrSel[i]),
            .hostCmd(reqA0),
            .hostWdata(reqData),
            .hostRdData(hostRdSel[i]),
            .ctlRd(ctlRdSel),
            .ctlWr(ctlWrSel),
            .ctlWdata(ctlWrData),
            .stateWr(stateSel),
            .stateVal(ctlStateVal),
            .health(portHealth),
            .attn(portAttn[i]),
            .dataIn(portDataIn[i]),
            .dataOut(portDataOut[i]),
            .cmdFlag(portCmd[i]),
            .inputFullFlag(portInputFullFlag[i]),
            .outputFullFlag(portOutputFullFlag[i]),
            .status(portStatus[i])
        );
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctlRvalid <= 1'h0;
            ctlRdata <= BYTE_RESET;
            ctlRcmd <= 1'h0;
            ctlRport <= PORT_SW;
            ctlPendValid <= 1'h0;
            ctlPendPort <= PORT_SW;
            ctlOutputFullFlag <= 3'h0;
        end else begin
            ctlRvalid <= ctlReadGo;
            ctlPendValid <= anyInputFull;
            ctlPendPort <= grant;
            ctlOutputFullFlag <= portOutputFullFlag;
            if (ctlReadGo) begin
                ctlRdata <= portDataIn[grant];
                ctlRcmd <= portCmd[grant];
                ctlRport <= grant;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            healthReg <= HEALTH_READY;
            swAttn <= 1'h0;
            mgmtAttn <= 1'h0;
            hostAttnIrq <= 1'h0;
        end else begin
            healthReg <= ctlBusy ? HEALTH_NOT_READY : ctlHealth;
            swAttn <= swAttnCond;
            mgmtAttn <= mgmtMsgPending;
            // Level follows the flag, so the interrupt rises in the same edge as the flag
            hostAttnIrq <= globalIrqEnable & swAttnCond;
        end
    end

    // Queue storage needs no reset; count and pointers decide what is valid
    always_ff @(posedge mclk) begin
        if (rxqDoPush) begin
            rxqMem[rxqWptr] <= rxqData;
        end
    end

    // A push into a full queue is dropped, like a message that finds no room
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rxqWptr <= 1'h0;
            rxqRptr <= 1'h0;
            rxqCount <= RXQ_EMPTY_COUNT;
        end else begin
            rxqCount <= next_rxqCount;
            if (rxqDoPush) begin
                rxqWptr <= ~rxqWptr;
            end
            if (rxqMove) begin
                rxqRptr <= ~rxqRptr;
            end
        end
    end

    // Software port write-phase tracking for abort and unit-number checks
    wire swCmdWr = hostWrSel[PORT_SW] & reqA0;
    wire swDataWr = hostWrSel[PORT_SW] & ~reqA0;
    wire abortHit = swCmdWr & (reqData == CMD_GET_STATUS_ABORT);
    wire lunBad = swDataWr & (trk == TRK_EXPECT_NETFN) & (reqData[1:0] != LUN_ACCEPTED);

    always_comb begin
        next_trk = trk;
        if (swCmdWr) begin
            if (reqData == CMD_WRITE_START) begin
                next_trk = TRK_EXPECT_NETFN;
            end else if (reqData == CMD_WRITE_END && trk != TRK_IDLE) begin
                next_trk = TRK_LAST;
            end else begin
                next_trk = TRK_IDLE;
            end
        end else if (swDataWr) begin
            case (trk)
                TRK_IDLE: next_trk = TRK_IDLE;
                TRK_EXPECT_NETFN: next_trk = TRK_BODY;
                TRK_BODY: next_trk = TRK_BODY;
                TRK_LAST: next_trk = TRK_IDLE;
                default: next_trk = TRK_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            trk <= TRK_IDLE;
            swAbortFlag <= 1'h0;
            swLunErr <= 1'h0;
        end else begin
            trk <= next_trk;
            swAbortFlag <= abortHit | (swAbortFlag & ~ctlFlagClr);
            swLunErr <= lunBad | (swLunErr & ~ctlFlagClr);
        end
    end

    // ---------------- Checks ----------------
    property p_priority;
        @(posedge mclk) disable iff (rst) portInputFullFlag[PORT_MGMT] |=> ctlPendValid && (ctlPendPort == PORT_MGMT);
    endproperty
    a_priority: assert property (p_priority) else $error("management port not granted first");

    property p_reset_state;
        @(posedge mclk) disable iff (rst) $past(rst) |-> (portStatus[PORT_SW][7:4] == 4'hc) && !swAttn;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("wrong status after reset");

    property p_busy_health;
        @(posedge mclk) disable iff (rst)
            ctlBusy |=> (portStatus[PORT_SW][5:4] == HEALTH_NOT_READY) && (portStatus[PORT_MGMT][5:4] == HEALTH_NOT_READY);
    endproperty
    a_busy_health: assert property (p_busy_health) else $error("health not forced to not ready");

    property p_irq;
        @(posedge mclk) disable iff (rst) $rose(swAttn) && $past(globalIrqEnable) |-> hostAttnIrq;
    endproperty
    a_irq: assert property (p_irq) else $error("host interrupt missing on attention set");

    property p_attn_set;
        @(posedge mclk) disable iff (rst) (eventPending || preTimeout || rxqCount != RXQ_EMPTY_COUNT) |=> portStatus[PORT_SW][2];
    endproperty
    a_attn_set: assert property (p_attn_set) else $error("software attention not set");

    property p_attn_clr;
        @(posedge mclk) disable iff (rst) swAttn ##1 !swAttn |-> $past(!swAttnCond) && $past(!swMsgPending);
    endproperty
    a_attn_clr: assert property (p_attn_clr) else $error("software attention cleared early");

    sequence s_bad_lun;
        lunBad;
    endsequence
    property p_lun;
        @(posedge mclk) disable iff (rst) s_bad_lun |=> swLunErr [*1] ##1 (swLunErr || $past(ctlFlagClr));
    endproperty
    a_lun: assert property (p_lun) else $error("bad logical unit not flagged");

    property p_abort;
        @(posedge mclk) disable iff (rst) abortHit |=> swAbortFlag && (trk == TRK_IDLE);
    endproperty
    a_abort: assert property (p_abort) else $error("abort request not recorded");

    property p_rxq_move;
        @(posedge mclk) disable iff (rst)
            rxqMove && !rxqPush |=> portOutputFullFlag[PORT_SW] && (rxqCount == $past(rxqCount) - 2'h1);
    endproperty
    a_rxq_move: assert property (p_rxq_move) else $error("queue entry not moved to software port");

endmodule // khp_host_port_set

// file: khp_host_model.sv
// Host-side bus master model that drives the byte ports over the link clock
`timescale 1ns/1ps
module khp_host_model (
    input wire logic lclk,
    output logic [15:0] ioAddr,
    output logic ioWrite,
    output logic ioRead,
    output logic [7:0] ioWdata,
    input wire logic [7:0] ioRdata,
    input wire logic ioDone
);
    initial begin
        ioAddr = 16'h0000;
        ioWrite = 1'b0;
        ioRead = 1'b0;
        ioWdata = 8'h00;
    end

    // Sole master on the link, one access outstanding; gives up after 24 cycles
    task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] wd,
        output logic [7:0] rd, output logic ok);
        int n;
        ok = 1'b0;
        rd = 8'h00;
        @(posedge lclk);
        ioAddr <= a;
        ioWdata <= wd;
        ioWrite <= wr;
        ioRead <= !wr;
        @(posedge lclk);
        ioWrite <= 1'b0;
        ioRead <= 1'b0;
        // Released lines carry the inverse so a late sample cannot pass for valid
        ioAddr <= ~a;
        ioWdata <= ~wd;
        for (n = 0; n < 24 && !ok; n++) begin
            @(posedge lclk);
            if (ioDone === 1'b1) begin
                ok = 1'b1;
                rd = ioRdata;
            end
        end
    endtask
endmodule // khp_host_model

// file: tb.sv
// Self-checking bench for the three-port host byte interface
`timescale 1ns/1ps
module tb;
    import khp_pkg::*;
    logic mclk = 1'b0, lclk = 1'b0, rst = 1'b1;
    logic [15:0] ioAddr;
    logic ioWrite, ioRead, ioDone, ioBusy, ok;
    logic [7:0] ioWdata, ioRdata, rd, ctlRdata;
    logic ctlRead = 1'b0, ctlWrite = 1'b0, ctlStateWr = 1'b0, ctlBusy = 1'b0, ctlFlagClr = 1'b0;
    logic mgmtMsgPending = 1'b0, swMsgPending = 1'b0, eventPending = 1'b0, preTimeout = 1'b0;
    logic globalIrqEnable = 1'b0, rxqPush = 1'b0, rxqToHost = 1'b0;
    logic [1:0] ctlWport = 2'h0, ctlStatePort = 2'h0, ctlStateVal = 2'h0, ctlHealth = 2'h0;
    logic [7:0] ctlWdata = 8'h00, rxqData = 8'h00;
    logic ctlRvalid, ctlRcmd, ctlPendValid, hostAttnIrq, swAbortFlag, swLunErr;
    logic [1:0] ctlRport, ctlPendPort, rxqCount;
    logic [2:0] ctlOutputFullFlag;
    logic [1:0] ord [3] = '{2'h1, 2'h0, 2'h2};
    int n_fail = 0, comparisons = 0;

    always #4 mclk = ~mclk;
    always #6 lclk = ~lclk;

    khp_host_model host (.lclk(lclk), .ioAddr(ioAddr), .ioWrite(ioWrite), .ioRead(ioRead),
        .ioWdata(ioWdata), .ioRdata(ioRdata), .ioDone(ioDone));

    khp_host_port_set dut (.mclk(mclk), .rst(rst), .lclk(lclk), .ioAddr(ioAddr), .ioWrite(ioWrite),
        .ioRead(ioRead), .ioWdata(ioWdata), .ioRdata(ioRdata), .ioDone(ioDone), .ioBusy(ioBusy),
        .ctlRead(ctlRead), .ctlRvalid(ctlRvalid), .ctlRdata(ctlRdata), .ctlRcmd(ctlRcmd),
        .ctlRport(ctlRport), .ctlPendValid(ctlPendValid), .ctlPendPort(ctlPendPort),
        .ctlOutputFullFlag(ctlOutputFullFlag),
        .ctlWrite(ctlWrite), .ctlWport(ctlWport), .ctlWdata(ctlWdata), .ctlStateWr(ctlStateWr),
        .ctlStatePort(ctlStatePort), .ctlStateVal(ctlStateVal), .ctlHealth(ctlHealth), .ctlBusy(ctlBusy),
        .mgmtMsgPending(mgmtMsgPending), .swMsgPending(swMsgPending), .eventPending(eventPending),
        .preTimeout(preTimeout), .globalIrqEnable(globalIrqEnable), .hostAttnIrq(hostAttnIrq),
        .rxqPush(rxqPush), .rxqData(rxqData), .rxqToHost(rxqToHost), .rxqCount(rxqCount),
        .ctlFlagClr(ctlFlagClr), .swAbortFlag(swAbortFlag), .swLunErr(swLunErr));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic hw(input logic [15:0] a, input logic [7:0] d);
        host.access(1'b1, a, d, rd, ok);
        chk({6'h0, ioBusy, ok}, 8'h01);
    endtask

    task automatic hr(input logic [15:0] a, input logic [7:0] e);
        host.access(1'b0, a, 8'h00, rd, ok);
        chk(rd, e);
    endtask

    // Status crosses into the link domain, so give it a few cycles to land
    task automatic settle;
        repeat (6) @(posedge mclk);
    endtask

    task automatic cread(input logic [7:0] d, input logic c, input logic [1:0] p);
        @(posedge mclk) ctlRead <= 1'b1;
        @(posedge mclk) ctlRead <= 1'b0;
        #1;
        chk({ctlRvalid, ctlRcmd, 4'h0, ctlRport}, {1'b1, c, 4'h0, p});
        chk(ctlRdata, d);
        settle;
    endtask

    task automatic final_report;
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #200000;
        n_fail++;
        final_report;
    end

    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        repeat (8) @(posedge lclk);
        for (int p = 0; p < 3; p++) begin
            hr(SW_PORT_BASE + 16'(2 * p + 1), 8'hc0);
        end
        host.access(1'b0, 16'h0ca8, 8'h00, rd, ok);
        chk({7'h0, ok}, 8'h00);
        $display("reset and decode done");
        hw(16'h0ca2, 8'h55);
        hr(16'h0ca3, 8'hc2);
        hw(16'h0ca3, CMD_GET_STATUS_ABORT);
        hr(16'h0ca3, 8'hca);
        cread(CMD_GET_STATUS_ABORT, 1'b1, PORT_SW);
        chk({7'h0, swAbortFlag}, 8'h01);
        hr(16'h0ca3, 8'hc8);
        hw(16'h0ca3, CMD_WRITE_START);
        cread(CMD_WRITE_START, 1'b1, PORT_SW);
        hw(16'h0ca2, 8'h19);
        cread(8'h19, 1'b0, PORT_SW);
        chk({7'h0, swLunErr}, 8'h01);
        @(posedge mclk) ctlFlagClr <= 1'b1;
        @(posedge mclk) ctlFlagClr <= 1'b0;
        settle;
        chk({6'h0, swAbortFlag, swLunErr}, 8'h00);
        hr(16'h0ca3, 8'hc0);
        $display("command and data done");
        for (int p = 0; p < 3; p++) begin
            hw(SW_PORT_BASE + 16'(2 * p), 8'(p + 1));
        end
        settle;
        for (int i = 0; i < 3; i++) begin
            chk({ctlPendValid, 5'h0, ctlPendPort}, {1'b1, 5'h0, ord[i]});
            cread(8'(ord[i]) + 8'h01, 1'b0, ord[i]);
        end
        chk({7'h0, ctlPendValid}, 8'h00);
        $display("priority done");
        @(posedge mclk) begin
            ctlWrite <= 1'b1;
            ctlWport <= PORT_EC;
            ctlWdata <= 8'ha5;
        end
        @(posedge mclk) ctlWrite <= 1'b0;
        settle;
        chk({5'h0, ctlOutputFullFlag}, 8'h04);
        hr(16'h0ca7, 8'hc1);
        hr(16'h0ca6, 8'ha5);
        settle;
        hr(16'h0ca7, 8'hc0);
        chk({5'h0, ctlOutputFullFlag}, 8'h00);
        $display("output full done");
        for (int h = 0; h < 4; h++) begin
            @(posedge mclk) ctlHealth <= 2'(h);
            settle;
            hr(16'h0ca3, {2'b11, 2'(h), 4'h0});
            hr(16'h0ca5, {2'b11, 2'(h), 4'h0});
            hr(16'h0ca7, 8'hc0);
        end
        @(posedge mclk) begin
            ctlHealth <= HEALTH_READY;
            ctlBusy <= 1'b1;
        end
        settle;
        hr(16'h0ca3, 8'hf0);
        @(posedge mclk) begin
            ctlBusy <= 1'b0;
            ctlStateWr <= 1'b1;
            ctlStatePort <= PORT_MGMT;
        end
        @(posedge mclk) ctlStateWr <= 1'b0;
        settle;
        hr(16'h0ca5, 8'h00);
        // All ones at the odd address would show up in status if the write reached it
        hw(16'h0ca5, 8'hff);
        hr(16'h0ca5, 8'h0a);
        cread(8'hff, 1'b1, PORT_MGMT);
        $display("health and state done");
        @(posedge mclk) begin
            globalIrqEnable <= 1'b1;
            mgmtMsgPending <= 1'b1;
            rxqPush <= 1'b1;
            rxqData <= 8'h11;
        end
        @(posedge mclk) rxqData <= 8'h22;
        @(posedge mclk) rxqData <= 8'h33;
        @(posedge mclk) rxqPush <= 1'b0;
        settle;
        chk({6'h0, rxqCount}, 8'h02);
        chk({7'h0, hostAttnIrq}, 8'h01);
        hr(16'h0ca3, 8'hc4);
        hr(16'h0ca5, 8'h0c);
        @(posedge mclk) eventPending <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            @(posedge mclk) rxqToHost <= 1'b1;
            @(posedge mclk) rxqToHost <= 1'b0;
            settle;
            hr(16'h0ca3, 8'hc5);
            hr(16'h0ca2, 8'h11 * 8'(i + 1));
        end
        settle;
        hr(16'h0ca3, 8'hc4);
        @(posedge mclk) eventPending <= 1'b0;
        settle;
        hr(16'h0ca3, 8'hc0);
        chk({7'h0, hostAttnIrq}, 8'h00);
        @(posedge mclk) preTimeout <= 1'b1;
        settle;
        hr(16'h0ca3, 8'hc4);
        chk({7'h0, hostAttnIrq}, 8'h01);
        @(posedge mclk) globalIrqEnable <= 1'b0;
        settle;
        chk({7'h0, hostAttnIrq}, 8'h00);
        @(posedge mclk) begin
            preTimeout <= 1'b0;
            swMsgPending <= 1'b1;
        end
        settle;
        hr(16'h0ca3, 8'hc4);
        @(posedge mclk) swMsgPending <= 1'b0;
        settle;
        hr(16'h0ca3, 8'hc0);
        $display("attention done");
        final_report;
    end
endmodule // tb
